// *** design/conv_port_regs.svh ***
`ifndef CONV_PORT_REGS_SVH
`define CONV_PORT_REGS_SVH
// Behaviour
// R01 - Differential negative result reads as zero
// R02 - Mode bit one means single-ended
// R03 - Polarity bit swaps differential input roles
// R04 - Every transaction takes a fresh address
// R05 - Host holds select low whole transaction
// R06 - Rising edges shift; first one starts
// R07 - Two address bits follow start bit
// R08 - Half clock settling before conversion begins
// R09 - Serial input ignored after address capture
// R10 - Third falling edge drives leading zero
// R11 - Decisions shift out MSB first, falling
// R12 - Eight decisions give eight-bit result
// R13 - Result copied, then shifted LSB first
// R14 - Output low after tail until deselect
// R15 - Output high impedance while addressing
// R16 - Deselect enters static low power state
// R17 - Low power releases the output driver
// R18 - Positive sampled once, negative per decision
// R19 - Early deselect abandons, awaits new start

// ---------------------------------------------------------------
// Sizes and levels
// ---------------------------------------------------------------
`define RESULT_BITS   8      // Width of a conversion result
`define MODE_SINGLE   1'b1   // Mode bit value for single-ended
`define POL_SWAPPED   1'b1   // Polarity bit value choosing ch1
`define START_LEVEL   1'b1   // Serial input level of a start bit
`define LEAD_LEVEL    1'b0   // Level driven while settling / after
`define SEL_IDLE      1'b1   // Select level when host is idle
`define PIN_LOW       1'b0   // Reset level of the other pins
`define OE_OFF        1'b0   // Output driver released
`define OE_ON         1'b1   // Output driver active
`endif

// *** design/conv_port_pkg.sv ***
`include "conv_port_regs.svh"

package conv_port_pkg;

   // Pins coming from the host
   typedef struct packed {
      logic conv_select_n;   // Active-low transaction select
      logic serial_clk;      // Host-supplied bit clock
      logic serial_in;       // Address line from host
   } link_in_t;

   // Serial output pin as three-state pair
   typedef struct packed {
      logic serial_out;      // Output level
      logic serial_out_oe;   // High while the pin is driven
   } link_out_t;

   // Multiplexer address carried in a transaction
   typedef struct packed {
      logic single_diff_sel;       // 1 single-ended, 0 differential
      logic channel_polarity_sel;  // Channel or polarity choice
   } mux_addr_t;

   // Transaction sequencer states
   typedef enum logic [2:0] {
      st_power_down,
      st_wait_start,
      st_get_mode,
      st_get_polarity,
      st_settle,
      st_convert,
      st_lsb_tail,
      st_hold_low
   } port_state_t;

endpackage : conv_port_pkg

// *** design/approximation_engine.sv ***
`timescale 1ns/1ps
`include "conv_port_regs.svh"

// ---------------------------------------------------------------
// Successive approximation engine on digital input levels
// ---------------------------------------------------------------
module approximation_engine #(
   parameter int WIDTH = `RESULT_BITS
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Control strobes
   input  wire logic             acquire,    // Hold positive input
   input  wire logic             decide,     // Make one decision
   // Input levels
   input  wire logic [WIDTH-1:0] pos_level,  // Positive input now
   input  wire logic [WIDTH-1:0] neg_level,  // Negative input now
   // Decision and result
   output logic                  decision,   // Bit of this decision
   output logic [WIDTH-1:0]      result_next // Register after it
);

   // Refuse widths that leave no room for a bit pointer
   if (WIDTH < 2) begin : g_width_check
      $error("approximation_engine: WIDTH below 2");
   end

   logic [WIDTH-1:0]         pos_hold_q;     // Held positive level
   logic [WIDTH-1:0]         approximation_register_q; // Trial bits
   logic [$clog2(WIDTH)-1:0] bit_idx_q;      // Bit under trial
   logic [WIDTH-1:0]         trial;          // Trial level
   logic [WIDTH-1:0]         difference;     // Clamped input diff

   // Difference of the pair, clamped at zero when negative
   function automatic logic [WIDTH-1:0] clamp_diff(
      input logic [WIDTH-1:0] pos,
      input logic [WIDTH-1:0] neg);
      clamp_diff = (pos > neg) ? WIDTH'(pos - neg) : '0; // R01
   endfunction : clamp_diff

   // Comparator against the trial level
   always_comb begin
      trial       = approximation_register_q;
      trial[bit_idx_q] = 1'b1;
      difference  = clamp_diff(pos_hold_q, neg_level); // R18
      decision    = (difference >= trial); // R11
      result_next = approximation_register_q;
      result_next[bit_idx_q] = decision;
   end

   // Positive input caught once per conversion
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pos_hold_q <= '0;
      end else if (acquire) begin
         pos_hold_q <= pos_level; // R18
      end
   end

   // Trial register and bit pointer, MSB downwards
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         approximation_register_q <= '0;
         bit_idx_q                <= '0;
      end else if (acquire) begin
         approximation_register_q <= '0;
         bit_idx_q <= ($clog2(WIDTH))'(WIDTH - 1); // R12
      end else if (decide) begin
         approximation_register_q <= result_next;
         bit_idx_q <= bit_idx_q - 1'b1;
      end
   end

endmodule : approximation_engine

// *** design/serial_adc_mux_conversion_port.sv ***
`timescale 1ns/1ps
`include "conv_port_regs.svh"

// ---------------------------------------------------------------
// Serial control and readout of a two-channel converter
// ---------------------------------------------------------------
module serial_adc_mux_conversion_port
   import conv_port_pkg::*;
#(
   parameter int WIDTH = `RESULT_BITS
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Host link pins
   input  wire link_in_t         link_in,
   output link_out_t             link_out,
   // Analog inputs as digital levels
   input  wire logic [WIDTH-1:0] chan0_level,
   input  wire logic [WIDTH-1:0] chan1_level,
   // Status towards the core
   output logic                  low_power,
   output mux_addr_t             mux_addr,
   output logic [WIDTH-1:0]      result,
   output logic                  result_valid
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (WIDTH < 2) begin : g_width_check
      $error("conversion port: WIDTH below 2");
   end

   localparam int CW = $clog2(WIDTH + 1);   // Counter width

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   link_in_t         meta_q;         // First synchroniser stage
   link_in_t         sync_q;         // Second synchroniser stage
   logic             clk_prev_q;     // Previous synced bit clock
   logic             clk_rise;       // Bit clock rising edge
   logic             clk_fall;       // Bit clock falling edge
   logic             selected;       // Select held low by host
   port_state_t      state_q;        // Sequencer state
   port_state_t      state_d;        // Next sequencer state
   logic [CW-1:0]    count_q;        // Bits moved in this phase
   mux_addr_t        addr_q;         // Captured mux address
   logic [WIDTH-1:0] shift_q;        // LSB-first output shifter
   logic             out_q;          // Serial output level
   logic             oe_q;           // Serial output enable
   logic             low_power_q;    // Low power indication
   logic [WIDTH-1:0] result_q;       // Last complete result
   logic             valid_q;        // Result strobe
   logic             acquire;        // Hold positive input
   logic             decide;         // One approximation step
   logic             last_decide;    // Final approximation step
   logic             decision;       // Comparator outcome
   logic [WIDTH-1:0] result_next;    // Register after decision
   logic [WIDTH-1:0] pos_level;      // Routed positive input
   logic [WIDTH-1:0] neg_level;      // Routed negative input

   // Edge of a synchronised level against its previous value
   function automatic logic edge_of(
      input logic now_lvl,
      input logic was_lvl,
      input logic rising);
      edge_of = rising ? (now_lvl & ~was_lvl) : (~now_lvl & was_lvl);
   endfunction : edge_of

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------

   // Two stages on every host pin before any logic looks at it
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         meta_q <= '{conv_select_n: `SEL_IDLE,
                     serial_clk:    `PIN_LOW,
                     serial_in:     `PIN_LOW};
         sync_q <= '{conv_select_n: `SEL_IDLE,
                     serial_clk:    `PIN_LOW,
                     serial_in:     `PIN_LOW};
      end else begin
         meta_q <= link_in;
         sync_q <= meta_q;
      end
   end

   // Previous bit clock level for edge detection
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         clk_prev_q <= `PIN_LOW;
      end else begin
         clk_prev_q <= sync_q.serial_clk;
      end
   end

   // Edges and select, all from the second stage
   assign clk_rise = edge_of(sync_q.serial_clk, clk_prev_q, 1'b1);
   assign clk_fall = edge_of(sync_q.serial_clk, clk_prev_q, 1'b0);
   assign selected = ~sync_q.conv_select_n; // R05

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------

   // Next state from edges and select
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         // Parked until the host selects
         st_power_down: begin
            if (selected) begin
               state_d = st_wait_start;
            end
         end
         // Leading zeros pass, first one is the start bit
         st_wait_start: begin
            if (clk_rise && sync_q.serial_in == `START_LEVEL) begin
               state_d = st_get_mode; // R06
            end
         end
         // Mode bit follows the start bit
         st_get_mode: begin
            if (clk_rise) begin
               state_d = st_get_polarity; // R07
            end
         end
         // Polarity bit closes the address
         st_get_polarity: begin
            if (clk_rise) begin
               state_d = st_settle; // R07
            end
         end
         // Half a clock for the input to settle
         st_settle: begin
            if (clk_fall) begin
               state_d = st_convert; // R08
            end
         end
         // One decision per falling edge
         st_convert: begin
            if (last_decide) begin
               state_d = st_lsb_tail; // R12
            end
         end
         // Remaining bits, LSB first
         st_lsb_tail: begin
            if (clk_fall && count_q == CW'(WIDTH - 2)) begin
               state_d = st_hold_low;
            end
         end
         // Quiet low until deselect
         st_hold_low: begin
            state_d = st_hold_low; // R14
         end
      endcase
      // Deselect wins from any state
      if (!selected) begin
         state_d = st_power_down; // R16 R19
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= st_power_down;
      end else begin
         state_q <= state_d;
      end
   end

   // Approximation strobes
   assign acquire     = selected && state_q == st_settle && clk_fall;
   assign decide      = selected && state_q == st_convert && clk_fall;
   assign last_decide = decide && count_q == CW'(WIDTH - 1);

   // Bit counter for conversion and tail phases
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_q <= '0;
      end else if (!selected || acquire || last_decide) begin
         count_q <= '0;
      end else if (clk_fall && (state_q == st_convert ||
                                state_q == st_lsb_tail)) begin
         count_q <= count_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Address capture and input routing
   // ---------------------------------------------------------------

   // Address bits taken on their rising edges, then frozen
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         addr_q <= '0;
      end else if (selected && clk_rise) begin
         if (state_q == st_get_mode) begin
            addr_q.single_diff_sel <= sync_q.serial_in; // R04
         end else if (state_q == st_get_polarity) begin // R09
            addr_q.channel_polarity_sel <= sync_q.serial_in; // R04
         end
      end
   end

   // Positive and negative inputs from the captured address
   always_comb begin
      if (addr_q.channel_polarity_sel == `POL_SWAPPED) begin
         pos_level = chan1_level; // R02 R03
         neg_level = chan0_level; // R03
      end else begin
         pos_level = chan0_level; // R02 R03
         neg_level = chan1_level; // R03
      end
      // Single-ended inputs compare against ground
      if (addr_q.single_diff_sel == `MODE_SINGLE) begin
         neg_level = '0; // R02
      end
   end

   // ---------------------------------------------------------------
   // Approximation engine
   // ---------------------------------------------------------------
   approximation_engine #(
      .WIDTH (WIDTH)
   ) u_engine (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .acquire     (acquire),
      .decide      (decide),
      .pos_level   (pos_level),
      .neg_level   (neg_level),
      .decision    (decision),
      .result_next (result_next)
   );

   // ---------------------------------------------------------------
   // Output path
   // ---------------------------------------------------------------

   // Tail shifter loaded with the finished result
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         shift_q <= '0;
      end else if (last_decide) begin
         shift_q <= result_next; // R13
      end else if (selected && clk_fall && state_q == st_lsb_tail) begin
         shift_q <= shift_q >> 1;
      end
   end

   // Serial output level and driver enable
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         out_q <= `LEAD_LEVEL;
         oe_q  <= `OE_OFF;
      end else if (!selected) begin
         out_q <= `LEAD_LEVEL;
         oe_q  <= `OE_OFF; // R17
      end else if (acquire) begin
         out_q <= `LEAD_LEVEL; // R10
         oe_q  <= `OE_ON; // R10
      end else if (decide) begin
         out_q <= decision; // R11
      end else if (clk_fall && state_q == st_lsb_tail) begin
         out_q <= shift_q[1]; // R13
      end else if (clk_fall && state_q == st_hold_low) begin
         out_q <= `LEAD_LEVEL; // R14
      end
   end
   // Addressing leaves the driver released, so the pins may share
   // one wire; input is only read in the start and address states
   assign link_out = '{serial_out: out_q, serial_out_oe: oe_q}; // R15

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------

   // Low power flag and result strobe
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         low_power_q <= 1'b1;
         valid_q     <= 1'b0;
      end else begin
         low_power_q <= (state_d == st_power_down); // R16
         valid_q     <= last_decide;
      end
   end

   // Finished result held for the core
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         result_q <= '0;
      end else if (last_decide) begin
         result_q <= result_next; // R12
      end
   end

   assign low_power    = low_power_q;
   assign mux_addr     = addr_q;
   assign result       = result_q;
   assign result_valid = valid_q;

endmodule : serial_adc_mux_conversion_port

// *** bench/conv_port_props.sv ***
`timescale 1ns/1ps
// ----
// Port checker
// ----
module conv_port_props
   import conv_port_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic             core_clk,
   input wire logic             reset_n,
   // Link pins
   input wire link_in_t         link_in,
   input wire link_out_t        link_out,
   // Input levels
   input wire logic [WIDTH-1:0] chan0_level,
   input wire logic [WIDTH-1:0] chan1_level,
   // Status
   input wire logic             low_power,
   input wire mux_addr_t        mux_addr,
   input wire logic [WIDTH-1:0] result,
   input wire logic             result_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   wire             sel_hi = link_in.conv_select_n;  // Host idle
   wire             oe     = link_out.serial_out_oe; // Pin driven
   wire             sgl    = mux_addr.single_diff_sel;
   logic [WIDTH-1:0] pos;                            // Positive input
   logic [WIDTH-1:0] neg;                            // Negative input
   assign pos = mux_addr.channel_polarity_sel ? chan1_level : chan0_level;
   assign neg = mux_addr.channel_polarity_sel ? chan0_level : chan1_level;

   a_deselect_release: assert property (sel_hi [*7] |-> !oe)
      else $error("output driven while deselected");
   a_low_power_idle: assert property (sel_hi [*7] |-> low_power)
      else $error("no low power while deselected");
   a_abort_no_result: assert property (sel_hi [*7] |-> !result_valid)
      else $error("result while deselected");
   a_first_drive_zero: assert property ($rose(oe)
      |-> !link_out.serial_out)
      else $error("first driven bit not zero");
   a_single_code: assert property (result_valid && sgl
      |-> result == pos)
      else $error("single-ended code wrong");
   a_diff_code: assert property (result_valid && !sgl && pos > neg
      |-> result == pos - neg)
      else $error("differential code wrong");
   a_diff_neg_zero: assert property (result_valid && !sgl && pos <= neg
      |-> result == '0)
      else $error("negative difference not zero");
   a_valid_single: assert property (result_valid |=> !result_valid [*8])
      else $error("result strobe repeated");
   a_result_hold: assert property (!$stable(result) |-> result_valid)
      else $error("result changed without strobe");
   a_addr_fixed: assert property (oe |-> $stable(mux_addr))
      else $error("address changed after capture");
   a_valid_session: assert property (result_valid |-> oe && !low_power)
      else $error("result outside a transaction");
endmodule : conv_port_props

bind serial_adc_mux_conversion_port conv_port_props #(.WIDTH(WIDTH))
   u_conv_port_props (.core_clk(core_clk), .reset_n(reset_n),
   .link_in(link_in), .link_out(link_out), .chan0_level(chan0_level),
   .chan1_level(chan1_level), .low_power(low_power),
   .mux_addr(mux_addr), .result(result), .result_valid(result_valid));

// *** bench/host_link_model.sv ***
`timescale 1ns/1ps
// ----
// Host side of the serial link
// ----
module host_link_model
   import conv_port_pkg::*;
(
   // Clock
   input  wire logic       core_clk,
   // Transaction request
   input  wire logic       go,
   input  wire logic       mode,
   input  wire logic       pol,
   input  wire logic [1:0] lead,
   input  wire logic [5:0] abort_at,
   // Link pins
   output link_in_t        link_in,
   input  wire link_out_t  link_out,
   // Captured frame
   output logic            done,
   output logic            aborted,
   output logic [20:0]     frame
);
   localparam int HALF = 8;  // Core cycles per link clock phase

   // Wait some core clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // One select-low transaction; bit 20 oe in address, 19 oe lost
   task automatic run();
      int          n;
      int          top;
      logic        din;
      logic [20:0] f;
      top = 32'(lead) + 22;
      din = 1'b0;
      f = '0;
      link_in.conv_select_n <= 1'b0;
      tick(HALF);
      for (n = 0; n < top; n++) begin
         if (abort_at != 6'h00 && n == 32'(abort_at)) break;
         din = n < lead ? 1'b0 : n == lead ? 1'b1 :
               n == lead + 1 ? mode : n == lead + 2 ? pol : ~din;
         link_in.serial_in <= din;
         tick(HALF);
         link_in.serial_clk <= 1'b1;
         tick(HALF);
         if (n <= lead + 2) begin
            f[20] = f[20] | link_out.serial_out_oe;
         end else begin
            f[n - lead - 3] = link_out.serial_out;
            f[19] = f[19] | ~link_out.serial_out_oe;
         end
         link_in.serial_clk <= 1'b0;
      end
      aborted <= (n < top);
      frame <= f;
      link_in.conv_select_n <= 1'b1;
      link_in.serial_in <= ~din;  // Released line shows no old level
      tick(12);
      done <= 1'b1;
   endtask : run

   // Idle until asked, then run one transaction
   initial begin
      link_in = '{conv_select_n: 1'b1, serial_clk: 1'b0, serial_in: 1'b0};
      done = 1'b0;
      aborted = 1'b0;
      frame = '0;
      forever begin
         @(posedge core_clk);
         done <= 1'b0;
         if (go === 1'b1) run();
      end
   end
endmodule : host_link_model

// *** bench/serial_adc_mux_conversion_port_bench.sv ***
`timescale 1ns/1ps
// ----
// Bench for the serial converter port
// ----
module serial_adc_mux_conversion_port_bench;
   import conv_port_pkg::*;
   logic        core_clk;      // System clock
   logic        reset_n;       // Synchronous reset
   link_in_t    link_in;       // Host pins
   link_out_t   link_out;      // Device pin
   logic [7:0]  chan0_level;   // Channel 0 level
   logic [7:0]  chan1_level;   // Channel 1 level
   logic        low_power;     // Power state
   mux_addr_t   mux_addr;      // Captured address
   logic [7:0]  result;        // Finished code
   logic        result_valid;  // Code strobe
   logic        go;            // Host request
   logic        mode;          // Mode bit to send
   logic        pol;           // Polarity bit to send
   logic [1:0]  lead;          // Leading zeros to send
   logic [5:0]  abort_at;      // Link cycle of early deselect
   logic        done;          // Host finished
   logic        aborted;       // Host deselected early
   logic [20:0] frame;         // Host capture
   logic [9:0]  res_q[$];      // Expected address and code
   logic [20:0] frm_q[$];      // Expected frames
   logic [17:0] cases[9];      // Mode, polarity, ch0, ch1
   int          n_mismatch = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed;

   serial_adc_mux_conversion_port #(.WIDTH(8))
      u_serial_adc_mux_conversion_port (.core_clk(core_clk),
      .reset_n(reset_n), .link_in(link_in), .link_out(link_out),
      .chan0_level(chan0_level), .chan1_level(chan1_level),
      .low_power(low_power), .mux_addr(mux_addr), .result(result),
      .result_valid(result_valid));
   host_link_model u_host_link_model (.core_clk(core_clk), .go(go),
      .mode(mode), .pol(pol), .lead(lead), .abort_at(abort_at),
      .link_in(link_in), .link_out(link_out), .done(done),
      .aborted(aborted), .frame(frame));

   // Compare one result
   task automatic chk(input string what, input logic [20:0] exp,
                      input logic [20:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Compare one finished code with the address it used
   task automatic chk_result(input logic [9:0] exp);
      chk("result", 21'(exp), 21'({mux_addr, result}));
   endtask : chk_result

   // Compare one captured host frame
   task automatic chk_frame(input logic [20:0] exp);
      chk("frame", exp, frame);
   endtask : chk_frame

   // Compare power state and driver after a cut transaction
   task automatic chk_idle();
      chk("idle", 21'h2, 21'({low_power, link_out.serial_out_oe}));
   endtask : chk_idle

   // Report and end the run
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Note expectations, start the host, wait for it
   task automatic xfer(input logic [17:0] c, input logic [5:0] ab);
      logic [7:0]  r;
      logic [7:0]  ps;
      logic [7:0]  ng;
      logic [20:0] f;
      int          i;
      ps = c[16] ? c[7:0] : c[15:8];
      ng = c[17] ? 8'h00 : (c[16] ? c[15:8] : c[7:0]);
      r = ps > ng ? ps - ng : 8'h00;
      f = '0;
      for (i = 0; i < 8; i++) f[1 + i] = r[7 - i];
      for (i = 1; i < 8; i++) f[8 + i] = r[i];
      if (ab == 6'h00) begin
         res_q.push_back({c[17:16], r});
         frm_q.push_back(f);
      end
      {mode, pol} <= c[17:16];
      chan0_level <= c[15:8];
      chan1_level <= c[7:0];
      lead <= 2'($random(seed));
      abort_at <= ab;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      while (done !== 1'b1) @(posedge core_clk);
   endtask : xfer

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // Output watcher
   always @(posedge core_clk) begin
      if (result_valid === 1'b1) begin
         if (res_q.size() == 0) chk("spare result", 21'h0, 21'h1);
         else chk_result(res_q.pop_front());
      end
      if (done === 1'b1 && aborted === 1'b0) begin
         chk_frame(frm_q.pop_front());
      end
      if (done === 1'b1 && aborted === 1'b1) begin
         chk_idle();
      end
   end

   // Main sequence
   initial begin
      int k;
      cases = '{{2'b10, 8'hA5, 8'h3C}, {2'b11, 8'hA5, 8'h3C},
                {2'b00, 8'hC8, 8'h41}, {2'b01, 8'hC8, 8'h41},
                {2'b00, 8'h50, 8'h50}, {2'b10, 8'hFF, 8'h00},
                {2'b11, 8'h00, 8'hFF}, {2'b01, 8'h00, 8'hFF},
                {2'b00, 8'h01, 8'h00}};
      seed = 63345;
      reset_n = 1'b0;
      go = 1'b0;
      mode = 1'b0;
      pol = 1'b0;
      lead = 2'h0;
      abort_at = 6'h00;
      chan0_level = 8'h00;
      chan1_level = 8'h00;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (k = 0; k < 9; k++) xfer(cases[k], 6'h00);
      xfer(cases[0], 6'h02);
      xfer(cases[2], 6'h08); // Cut inside the decisions
      for (k = 0; k < 8; k++) xfer(18'($random(seed)), 6'h00);
      repeat (20) @(posedge core_clk);
      tally_and_finish();
   end
endmodule : serial_adc_mux_conversion_port_bench
